//--- ssdc_cfg.svh
// Constants of the solenoid setpoint, dither and clipping block
`ifndef SSDC_CFG_SVH
`define SSDC_CFG_SVH

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define SSDC_NCH 2
`define SSDC_AW 5
`define SSDC_DW 16
`define SSDC_TO_W 23

// ----------------------------------------------------------------
// Register offsets (word index)
// ----------------------------------------------------------------
`define SSDC_REG_CMD 2'h0
`define SSDC_REG_DITHER 2'h1
`define SSDC_REG_HYST 2'h2
`define SSDC_REG_STATUS 5'h10
`define SSDC_REG_MASK 5'h11
`define SSDC_REG_CHSTATE 5'h12

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SSDC_DIT_AMP_LSB 0
`define SSDC_DIT_FREQ_LSB 5
`define SSDC_DIT_ENH_BIT 11
`define SSDC_CMD_RESET 10'h000
`define SSDC_AMP_RESET 5'h00
`define SSDC_FREQ_RESET 6'h00
`define SSDC_HYST_RESET 3'h0
`define SSDC_MASK_RESET 4'h0

// ----------------------------------------------------------------
// Command and switch point limits, dither amplitude step
// ----------------------------------------------------------------
`define SSDC_CMD_OFF_MAX 10'h029
`define SSDC_CMD_MAX 10'h3D6
`define SSDC_SW_MIN 13'sh0019
`define SSDC_SW_MAX 13'sh03FF
`define SSDC_AMP_STEP 8'h15
`define SSDC_AMP_SHIFT 2

// Hysteresis in counts per setting 0..7
`define SSDC_HYST0 13'sh0011
`define SSDC_HYST1 13'sh0015
`define SSDC_HYST2 13'sh0019
`define SSDC_HYST3 13'sh001D
`define SSDC_HYST4 13'sh0021
`define SSDC_HYST5 13'sh0025
`define SSDC_HYST6 13'sh002A
`define SSDC_HYST7 13'sh002E

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSDC_CLK_MHZ 250
`define SSDC_DITHER_UNIT_NS 96154
`define SSDC_DITHER_UNIT_CYC ((`SSDC_DITHER_UNIT_NS*`SSDC_CLK_MHZ)/1000)
`define SSDC_ENH_TO_MS 20
`define SSDC_ENH_TO_CYC (`SSDC_ENH_TO_MS*`SSDC_CLK_MHZ*1000)

`endif

//--- ssdc_pkg.sv
// Types of the solenoid setpoint, dither and clipping block
`include "ssdc_cfg.svh"
package ssdc_pkg;

	typedef enum logic [3:0] {
		DP_IDLE = 4'b0001,
		DP_POS = 4'b0010,
		DP_NEG = 4'b0100,
		DP_EXT = 4'b1000
	} ssdc_dphase_t;

	typedef struct packed {
		ssdc_dphase_t dphase;
		logic [5:0] phase;
		logic crossed;
		logic [`SSDC_TO_W-1:0] to_cnt;
		logic wrap;
	} ssdc_dith_state_t;

	typedef struct packed {
		logic [9:0] cmd;
		logic [4:0] amp;
		logic [5:0] freq;
		logic enh;
		logic [2:0] hyst;
		logic sym;
		logic clip_seen;
		logic en;
		logic [9:0] up_pt;
		logic [9:0] lo_pt;
	} ssdc_chan_t;

endpackage

//--- ssdc_dither.sv
// Dither phase generator with enhanced-dither period extension
`timescale 1ns/1ps
`include "ssdc_cfg.svh"
module ssdc_dither import ssdc_pkg::*; #(
	parameter int TIMEOUT_CYCLES = `SSDC_ENH_TO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Control
	input wire logic tick,
	input wire logic run,
	input wire logic [5:0] freq,
	input wire logic enhanced,
	input wire logic lower_crossed,
	// Phase
	output logic positive,
	output logic extending,
	output logic wrap
);

	ssdc_dith_state_t s;
	ssdc_dith_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.wrap = 1'b0;
		if (!run) begin
			next_s.dphase = DP_IDLE;
			next_s.phase = 6'h00;
			next_s.crossed = 1'b0;
			next_s.to_cnt = '0;
		end else begin
			case (s.dphase)
				DP_IDLE: begin
					next_s.dphase = DP_POS;
					next_s.phase = 6'h00;
				end
				DP_POS: begin
					if (tick) begin
						// Lowering the code mid-half must not run on
						if (s.phase + 6'h01 >= freq) begin
							next_s.phase = 6'h00;
							next_s.dphase = DP_NEG;
							next_s.crossed = 1'b0;
						end else begin
							next_s.phase = s.phase + 6'h01;
						end
					end
				end
				DP_NEG: begin
					if (lower_crossed) begin
						next_s.crossed = 1'b1;
					end
					if (tick) begin
						if (s.phase + 6'h01 >= freq) begin
							next_s.phase = 6'h00;
							// Extend only if no crossing in the falling half
							if (enhanced && !s.crossed && !lower_crossed) begin
								next_s.dphase = DP_EXT;
								next_s.to_cnt = '0;
							end else begin
								next_s.dphase = DP_POS;
								next_s.wrap = 1'b1;
							end
						end else begin
							next_s.phase = s.phase + 6'h01;
						end
					end
				end
				DP_EXT: begin
					next_s.to_cnt = s.to_cnt + `SSDC_TO_W'(1);
					if (lower_crossed ||
					    s.to_cnt == `SSDC_TO_W'(TIMEOUT_CYCLES - 1)) begin
						next_s.dphase = DP_POS;
						next_s.wrap = 1'b1;
						next_s.to_cnt = '0;
					end
				end
				default: begin
					next_s.dphase = DP_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s.dphase <= DP_IDLE;
			s.phase <= 6'h00;
			s.crossed <= 1'b0;
			s.to_cnt <= '0;
			s.wrap <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	assign positive = (s.dphase == DP_POS);
	assign extending = (s.dphase == DP_EXT);
	assign wrap = s.wrap;

endmodule

//--- ssdc_top.sv
// Solenoid setpoint conditioning: clamping, dither and switch point clipping
`timescale 1ns/1ps
`include "ssdc_cfg.svh"
module ssdc_top import ssdc_pkg::*; #(
	parameter int NCH = `SSDC_NCH,
	parameter int UNIT_CYCLES = `SSDC_DITHER_UNIT_CYC,
	parameter int ENH_TIMEOUT_CYCLES = `SSDC_ENH_TO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [`SSDC_AW-1:0] reg_addr,
	input wire logic [`SSDC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`SSDC_DW-1:0] reg_rdata,
	// Current comparator feedback
	input wire logic [NCH-1:0] lower_crossed,
	// Switch points
	output logic [NCH-1:0] channel_output,
	output logic [NCH*10-1:0] upper_point,
	output logic [NCH*10-1:0] lower_point,
	// Interrupt
	output logic irq
);

	localparam int UCW = $clog2(UNIT_CYCLES + 1);
	localparam int SW = 2 * NCH;

	typedef struct packed {
		ssdc_chan_t [NCH-1:0] ch;
		logic [SW-1:0] status;
		logic [SW-1:0] mask;
		logic [`SSDC_DW-1:0] rdata;
		logic [UCW-1:0] tick_cnt;
	} ssdc_state_t;

	ssdc_state_t s;
	ssdc_state_t next_s;

	// ----------------------------------------------------------------
	// Hysteresis lookup and switch point clipping
	// ----------------------------------------------------------------
	function automatic logic signed [12:0] hyst_counts(
		input logic [2:0] code
	);
		logic signed [12:0] h;
		h = `SSDC_HYST0;
		case (code)
			3'h0: h = `SSDC_HYST0;
			3'h1: h = `SSDC_HYST1;
			3'h2: h = `SSDC_HYST2;
			3'h3: h = `SSDC_HYST3;
			3'h4: h = `SSDC_HYST4;
			3'h5: h = `SSDC_HYST5;
			3'h6: h = `SSDC_HYST6;
			3'h7: h = `SSDC_HYST7;
			default: h = `SSDC_HYST0;
		endcase
		return h;
	endfunction

	function automatic logic [9:0] clip_point(
		input logic signed [12:0] v
	);
		logic [9:0] r;
		r = v[9:0];
		if (v > `SSDC_SW_MAX) begin
			r = 10'(`SSDC_SW_MAX);
		end else if (v < `SSDC_SW_MIN) begin
			r = 10'(`SSDC_SW_MIN);
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Dither time base
	// ----------------------------------------------------------------
	logic tick;
	assign tick = (s.tick_cnt == UCW'(UNIT_CYCLES - 1));

	// ----------------------------------------------------------------
	// Per channel setpoint arithmetic
	// ----------------------------------------------------------------
	logic [NCH-1:0] ch_en;
	logic [NCH-1:0] static_clip;
	logic [NCH-1:0] clip_now;
	logic [NCH-1:0] dith_on;
	logic [NCH-1:0] positive;
	logic [NCH-1:0] extending;
	logic [NCH-1:0] wrap;
	logic [9:0] avg_eff [NCH];
	logic [9:0] up_next [NCH];
	logic [9:0] lo_next [NCH];

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			logic signed [12:0] h;
			logic signed [12:0] up_s;
			logic signed [12:0] lo_s;
			logic signed [12:0] amp_full;
			logic signed [12:0] room_up;
			logic signed [12:0] room_lo;
			logic signed [12:0] room;
			logic signed [12:0] amp_eff;
			logic signed [12:0] d_full;
			logic signed [12:0] d_eff;
			logic [12:0] amp_prod;

			assign ch_en[g] = (s.ch[g].cmd > `SSDC_CMD_OFF_MAX);
			always_comb begin
				if (!ch_en[g]) begin
					avg_eff[g] = 10'h000;
				end else if (s.ch[g].cmd > `SSDC_CMD_MAX) begin
					avg_eff[g] = `SSDC_CMD_MAX;
				end else begin
					avg_eff[g] = s.ch[g].cmd;
				end
			end

			assign h = hyst_counts(s.ch[g].hyst);
			assign up_s = $signed({3'h0, avg_eff[g]}) + h;
			assign lo_s = $signed({3'h0, avg_eff[g]}) - h;
			assign static_clip[g] = ch_en[g] &&
				(up_s > `SSDC_SW_MAX || lo_s < `SSDC_SW_MIN);

			// Either field zero disables; zero frequency alone cannot run
			assign dith_on[g] = ch_en[g] && (s.ch[g].freq != 6'h00) &&
				(s.ch[g].amp != 5'h00);
			// Quarter-count step: 5.25 counts per code on each side
			assign amp_prod = 13'((s.ch[g].amp * `SSDC_AMP_STEP) >>
				`SSDC_AMP_SHIFT);
			assign amp_full = $signed(amp_prod);
			assign d_full = positive[g] ? amp_full : -amp_full;
			// Checked against the live sum, not at configuration time
			assign clip_now[g] = dith_on[g] && !static_clip[g] &&
				(up_s + d_full > `SSDC_SW_MAX ||
				 lo_s + d_full < `SSDC_SW_MIN);

			// Equal headroom both sides keeps the average centred
			assign room_up = `SSDC_SW_MAX - up_s;
			assign room_lo = lo_s - `SSDC_SW_MIN;
			always_comb begin
				room = (room_up < room_lo) ? room_up : room_lo;
				if (room < 13'sh0000) begin
					room = 13'sh0000;
				end
				amp_eff = amp_full;
				if (s.ch[g].sym && room < amp_full) begin
					amp_eff = room;
				end
				d_eff = 13'sh0000;
				if (dith_on[g]) begin
					d_eff = positive[g] ? amp_eff : -amp_eff;
				end
			end

			assign up_next[g] = clip_point(up_s + d_eff);
			assign lo_next[g] = clip_point(lo_s + d_eff);

			ssdc_dither #(
				.TIMEOUT_CYCLES(ENH_TIMEOUT_CYCLES)
			) u_dither (
				.clk(clk),
				.srst(srst),
				.tick(tick),
				.run(dith_on[g]),
				.freq(s.ch[g].freq),
				.enhanced(s.ch[g].enh),
				.lower_crossed(lower_crossed[g]),
				.positive(positive[g]),
				.extending(extending[g]),
				.wrap(wrap[g])
			);

			assign channel_output[g] = s.ch[g].en;
			assign upper_point[g*10 +: 10] = s.ch[g].up_pt;
			assign lower_point[g*10 +: 10] = s.ch[g].lo_pt;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	logic in_chan;
	logic [1:0] sel_ch;
	logic [1:0] sel_reg;
	assign in_chan = (reg_addr[4] == 1'b0) && (32'(reg_addr[3:2]) < NCH);
	assign sel_ch = reg_addr[3:2];
	assign sel_reg = reg_addr[1:0];

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [SW-1:0] set_bits;
		logic [SW-1:0] clr_bits;
		logic [9:0] wcmd;
		logic cfg_wr;
		cfg_wr = 1'b0;
		set_bits = '0;
		clr_bits = '0;
		wcmd = reg_wdata[9:0];
		next_s = s;

		next_s.tick_cnt = tick ? '0 : s.tick_cnt + UCW'(1);

		for (int i = 0; i < NCH; i++) begin
			cfg_wr = reg_wr && in_chan && 32'(sel_ch) == i;
			next_s.ch[i].en = ch_en[i];
			next_s.ch[i].up_pt = up_next[i];
			next_s.ch[i].lo_pt = lo_next[i];

			if (reg_wr && in_chan && 32'(sel_ch) == i) begin
				case (sel_reg)
					`SSDC_REG_CMD: begin
						// Raw value kept for read-back
						next_s.ch[i].cmd = wcmd;
						if (wcmd <= `SSDC_CMD_OFF_MAX ||
						    wcmd > `SSDC_CMD_MAX) begin
							set_bits[2*i] = 1'b1;
						end
					end
					`SSDC_REG_DITHER: begin
						next_s.ch[i].amp = reg_wdata[`SSDC_DIT_AMP_LSB +: 5];
						next_s.ch[i].freq = reg_wdata[`SSDC_DIT_FREQ_LSB +: 6];
						next_s.ch[i].enh = reg_wdata[`SSDC_DIT_ENH_BIT];
					end
					`SSDC_REG_HYST: begin
						next_s.ch[i].hyst = reg_wdata[2:0];
					end
					default: begin
					end
				endcase
			end

			if (static_clip[i]) begin
				set_bits[2*i] = 1'b1;
			end
			if (clip_now[i]) begin
				set_bits[2*i+1] = 1'b1;
			end

			// Mode changes at period ends, and clears at once when dither stops:
			// enter and exit lag by at most one period
			if (!dith_on[i]) begin
				next_s.ch[i].sym = 1'b0;
				next_s.ch[i].clip_seen = 1'b0;
			end else if (wrap[i]) begin
				next_s.ch[i].sym = !cfg_wr &&
					(s.ch[i].clip_seen || clip_now[i]);
				next_s.ch[i].clip_seen = 1'b0;
			end else if (cfg_wr) begin
				// Judge new settings alone, so exit takes one period
				next_s.ch[i].clip_seen = 1'b0;
			end else if (clip_now[i]) begin
				next_s.ch[i].clip_seen = 1'b1;
			end
		end

		if (reg_wr && reg_addr == `SSDC_REG_STATUS) begin
			clr_bits = reg_wdata[SW-1:0];
		end
		// A new event in the clearing cycle survives
		next_s.status = (s.status & ~clr_bits) | set_bits;
		if (reg_wr && reg_addr == `SSDC_REG_MASK) begin
			next_s.mask = reg_wdata[SW-1:0];
		end

		next_s.rdata = '0;
		if (reg_rd) begin
			if (in_chan) begin
				case (sel_reg)
					`SSDC_REG_CMD: begin
						next_s.rdata[9:0] = s.ch[sel_ch].cmd;
					end
					`SSDC_REG_DITHER: begin
						next_s.rdata[`SSDC_DIT_AMP_LSB +: 5] = s.ch[sel_ch].amp;
						next_s.rdata[`SSDC_DIT_FREQ_LSB +: 6] = s.ch[sel_ch].freq;
						next_s.rdata[`SSDC_DIT_ENH_BIT] = s.ch[sel_ch].enh;
					end
					`SSDC_REG_HYST: begin
						next_s.rdata[2:0] = s.ch[sel_ch].hyst;
					end
					default: begin
					end
				endcase
			end else if (reg_addr == `SSDC_REG_STATUS) begin
				next_s.rdata[SW-1:0] = s.status;
			end else if (reg_addr == `SSDC_REG_MASK) begin
				next_s.rdata[SW-1:0] = s.mask;
			end else if (reg_addr == `SSDC_REG_CHSTATE) begin
				for (int i = 0; i < NCH; i++) begin
					next_s.rdata[4*i] = s.ch[i].en;
					next_s.rdata[4*i+1] = s.ch[i].sym;
					next_s.rdata[4*i+2] = extending[i];
					next_s.rdata[4*i+3] = dith_on[i];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < NCH; i++) begin
				s.ch[i].cmd <= `SSDC_CMD_RESET;
				s.ch[i].amp <= `SSDC_AMP_RESET;
				s.ch[i].freq <= `SSDC_FREQ_RESET;
				s.ch[i].enh <= 1'b0;
				s.ch[i].hyst <= `SSDC_HYST_RESET;
				s.ch[i].sym <= 1'b0;
				s.ch[i].clip_seen <= 1'b0;
				s.ch[i].en <= 1'b0;
				s.ch[i].up_pt <= 10'h000;
				s.ch[i].lo_pt <= 10'h000;
			end
			s.status <= '0;
			s.mask <= '0;
			s.rdata <= '0;
			s.tick_cnt <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign irq = |(s.status & s.mask);

endmodule

//--- ssdc_top_sva.sv
// Port checker for the setpoint conditioning block
`timescale 1ns/1ps
`include "ssdc_cfg.svh"
module ssdc_top_chk import ssdc_pkg::*; #(
	parameter int NCH = `SSDC_NCH,
	parameter int UNIT_CYCLES = `SSDC_DITHER_UNIT_CYC,
	parameter int ENH_TIMEOUT_CYCLES = `SSDC_ENH_TO_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Register port
	input wire logic [`SSDC_AW-1:0] reg_addr,
	input wire logic [`SSDC_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [`SSDC_DW-1:0] reg_rdata,
	// Feedback and outputs
	input wire logic [NCH-1:0] lower_crossed,
	input wire logic [NCH-1:0] channel_output,
	input wire logic [NCH*10-1:0] upper_point,
	input wire logic [NCH*10-1:0] lower_point,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire [9:0] up0 = upper_point[9:0];
	wire [9:0] lo0 = lower_point[9:0];
	sequence cmd_wr_s;
		reg_wr && reg_addr == 5'h00;
	endsequence
	sequence cmd_rd_s;
		reg_rd && reg_addr == 5'h00;
	endsequence
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not idle");
	raw_readback_a: assert property (cmd_wr_s ##1 cmd_rd_s
		|=> reg_rdata == {6'h00, $past(reg_wdata[9:0], 2)})
		else $error("command read back differs");
	low_cmd_off_a: assert property (cmd_wr_s ##0 reg_wdata[9:0] <= 10'h029
		|-> ##2 !channel_output[0])
		else $error("low command left channel on");
	valid_cmd_on_a: assert property (cmd_wr_s ##0 reg_wdata[9:0] > 10'h029
		|-> ##2 channel_output[0])
		else $error("valid command left channel off");
	lower_floor_a: assert property (channel_output[0] |-> lo0 >= 10'h019)
		else $error("lower point below floor");
	hyst_span_a: assert property (channel_output[0] && lo0 > 10'h019
		&& up0 < 10'h3FF |-> (up0 - lo0) inside {10'h022, 10'h02A, 10'h032,
		10'h03A, 10'h042, 10'h04A, 10'h054, 10'h05C})
		else $error("point spacing not a hysteresis value");
	irq_mask_a: assert property (reg_wr && reg_addr == 5'h11
		&& reg_wdata[3:0] == 4'h0 |=> !irq)
		else $error("interrupt with all sources masked");
	unmapped_read_a: assert property (reg_rd && reg_addr == 5'h03
		|=> reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
endmodule

bind ssdc_top ssdc_top_chk #(.NCH(NCH), .UNIT_CYCLES(UNIT_CYCLES),
	.ENH_TIMEOUT_CYCLES(ENH_TIMEOUT_CYCLES)) i_ssdc_top_chk (.clk(clk),
	.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.lower_crossed(lower_crossed), .channel_output(channel_output),
	.upper_point(upper_point), .lower_point(lower_point), .irq(irq));

//--- ssdc_coil_model.sv
// Comparator stand-in that reports lower switch point crossings
`timescale 1ns/1ps
module ssdc_coil_model import ssdc_pkg::*; #(
	parameter int NCH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Bench request and decay lag
	input wire logic [NCH-1:0] cross_req,
	input wire logic [3:0] lag,
	// Comparator feedback
	output logic [NCH-1:0] lower_crossed
);
	// Slow decay: the crossing shows lag+3 cycles after it is asked for
	logic [NCH-1:0][4:0] cnt;
	always_ff @(posedge clk) begin
		for (int c = 0; c < NCH; c++) begin
			lower_crossed[c] <= cnt[c] == 5'h01;
			if (srst) begin
				cnt[c] <= 5'h00;
			end else if (cross_req[c] && cnt[c] == 5'h00) begin
				cnt[c] <= {1'b0, lag} + 5'h02;
			end else if (cnt[c] != 5'h00) begin
				cnt[c] <= cnt[c] - 5'h01;
			end
		end
	end
endmodule

//--- test_solenoid_setpoint_dither_clipping.sv
// Self-checking bench for the setpoint conditioning block
`timescale 1ns/1ps
module test_solenoid_setpoint_dither_clipping import ssdc_pkg::*; ();
	localparam int UNIT = 4;
	logic [9:0] hc [8] = '{10'h011, 10'h015, 10'h019, 10'h01D, 10'h021,
		10'h025, 10'h02A, 10'h02E};
	logic [5:0] fc [9] = '{6'h34, 6'h23, 6'h1A, 6'h15, 6'h11, 6'h0F,
		6'h0D, 6'h0C, 6'h0A};
	logic [4:0] ra [5] = '{5'h10, 5'h11, 5'h00, 5'h01, 5'h12};
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [4:0] reg_addr = 5'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] cross_req = 2'h0;
	logic [3:0] lag = 4'h1;
	logic [15:0] reg_rdata, v;
	logic [1:0] lower_crossed, channel_output;
	logic [19:0] upper_point, lower_point;
	logic irq;
	logic [9:0] umax, umin;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	int gap, t0;

	always #2 clk = ~clk;

	ssdc_top #(.NCH(2), .UNIT_CYCLES(UNIT), .ENH_TIMEOUT_CYCLES(50))
		i_ssdc_top (.clk(clk), .srst(srst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .lower_crossed(lower_crossed),
		.channel_output(channel_output), .upper_point(upper_point),
		.lower_point(lower_point), .irq(irq));
	ssdc_coil_model #(.NCH(2)) i_ssdc_coil_model (.clk(clk), .srst(srst),
		.cross_req(cross_req), .lag(lag), .lower_crossed(lower_crossed));

	// ----------------------------------------
	// Access and check tasks
	// ----------------------------------------
	task automatic tally_and_finish();
		if (n_fail == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic w, input logic r, input logic [4:0] a,
		input logic [15:0] d);
		@(posedge clk);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, a, d);
		acc(1'b0, 1'b0, a, d);
	endtask
	task automatic rd(input logic [4:0] a);
		acc(1'b0, 1'b1, a, 16'h0000);
		acc(1'b0, 1'b0, a, 16'h0000);
		@(negedge clk);
		v = reg_rdata;
	endtask
	task automatic settle();
		repeat (3) @(negedge clk);
	endtask
	// Skips the first change so a half cut short by reprogramming is ignored
	task automatic watch(input int n);
		int k;
		int last;
		logic [9:0] p;
		k = 0;
		last = 0;
		gap = 0;
		umax = 10'h000;
		umin = 10'h3FF;
		p = upper_point[9:0];
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			if (upper_point[9:0] !== p) begin
				k++;
				if (k >= 3) gap = i - last;
				last = i;
				p = upper_point[9:0];
			end
			if (k >= 2 && p > umax) umax = p;
			if (k >= 2 && p < umin) umin = p;
		end
	endtask
	task automatic case_chk(input logic [2:0] h, input logic [9:0] c,
		input logic en, input logic [9:0] up, input logic [9:0] lo,
		input logic err);
		wr(5'h02, {13'h0000, h});
		wr(5'h00, 16'h0200);
		settle();
		wr(5'h10, 16'h000F);
		wr(5'h00, {6'h00, c});
		settle();
		chk({15'h0000, channel_output[0]}, {15'h0000, en});
		if (en) chk({6'h00, upper_point[9:0]}, {6'h00, up});
		if (en) chk({6'h00, lower_point[9:0]}, {6'h00, lo});
		rd(5'h00);
		chk(v, {6'h00, c});
		rd(5'h10);
		chk(v & 16'h0003, {15'h0000, err});
	endtask
	task automatic poll_ext(input logic want);
		for (int i = 0; i < 40; i++) begin
			rd(5'h12);
			if (v[2] === want) break;
		end
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_fail++;
			tally_and_finish();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		foreach (ra[i]) begin
			rd(ra[i]);
			chk(v, 16'h0000);
		end
		chk({14'h0000, channel_output}, 16'h0000);
		case_chk(3'h0, 10'h029, 1'b0, 10'h000, 10'h000, 1'b1);
		case_chk(3'h0, 10'h000, 1'b0, 10'h000, 10'h000, 1'b1);
		case_chk(3'h0, 10'h02A, 1'b1, 10'h03B, 10'h019, 1'b0);
		case_chk(3'h0, 10'h3D6, 1'b1, 10'h3E7, 10'h3C5, 1'b0);
		case_chk(3'h0, 10'h3E0, 1'b1, 10'h3E7, 10'h3C5, 1'b1);
		case_chk(3'h0, 10'h3FF, 1'b1, 10'h3E7, 10'h3C5, 1'b1);
		for (int h = 0; h < 8; h++) begin
			case_chk(3'(h), 10'h200, 1'b1, 10'h200 + hc[h], 10'h200 - hc[h],
				1'b0);
		end
		case_chk(3'h7, 10'h3D6, 1'b1, 10'h3FF, 10'h3A8, 1'b1);
		case_chk(3'h7, 10'h02A, 1'b1, 10'h058, 10'h019, 1'b1);
		case_chk(3'h0, 10'h200, 1'b1, 10'h211, 10'h1EF, 1'b0);
		wr(5'h04, 16'h03E0);
		settle();
		chk({6'h00, upper_point[19:10]}, 16'h03E7);
		chk({6'h00, lower_point[19:10]}, 16'h03C5);
		chk({15'h0000, irq}, 16'h0000);
		wr(5'h11, 16'h0004);
		settle();
		chk({15'h0000, irq}, 16'h0001);
		rd(5'h10);
		chk(v, 16'h0004);
		wr(5'h10, 16'h0004);
		settle();
		chk({15'h0000, irq}, 16'h0000);
		wr(5'h11, 16'h0000);
		wr(5'h03, 16'hFFFF);
		rd(5'h03);
		chk(v, 16'h0000);
		rd(5'h13);
		chk(v, 16'h0000);
		acc(1'b1, 1'b0, 5'h00, 16'h0155);
		acc(1'b0, 1'b1, 5'h00, 16'h0000);
		acc(1'b0, 1'b0, 5'h00, 16'h0000);
		@(negedge clk);
		chk(reg_rdata, 16'h0155);
		wr(5'h00, 16'h0200);
		for (int a = 4; a <= 28; a += 4) begin
			wr(5'h01, 16'(a) | 16'h0040);
			watch(3 * 2 * UNIT + 240);
			chk(16'(umax - umin), 16'(a * 21 / 2));
			chk({6'h00, umax}, 16'(10'h211 + a * 21 / 4));
		end
		foreach (fc[i]) begin
			wr(5'h01, {5'h00, fc[i], 5'h04});
			watch(3 * fc[i] * UNIT + 240);
			chk(16'(gap), 16'(fc[i] * UNIT));
		end
		rd(5'h12);
		chk(v & 16'h0008, 16'h0008);
		wr(5'h01, 16'h0000);
		settle();
		rd(5'h12);
		chk(v & 16'h0008, 16'h0000);
		watch(60);
		chk({6'h00, upper_point[9:0]}, 16'h0211);
		wr(5'h00, 16'h03D6);
		settle();
		wr(5'h10, 16'h000F);
		wr(5'h01, 16'h005C);
		watch(48);
		rd(5'h10);
		chk(v & 16'h0003, 16'h0002);
		rd(5'h12);
		chk(v & 16'h0002, 16'h0002);
		watch(48);
		chk({6'h00, umax}, 16'h03FF);
		chk({6'h00, umin}, 16'h03CF);
		wr(5'h01, 16'h0044);
		watch(40);
		rd(5'h12);
		chk(v & 16'h0002, 16'h0000);
		chk({6'h00, umax}, 16'h03FC);
		rd(5'h10);
		chk(v & 16'h0002, 16'h0002);
		wr(5'h00, 16'h0200);
		wr(5'h01, 16'h0844);
		rd(5'h01);
		chk(v, 16'h0844);
		for (int i = 0; i < 2; i++) begin
			poll_ext(1'b1);
			chk({15'h0000, v[2]}, 16'h0001);
			chk({6'h00, lower_point[9:0]}, 16'h01DA);
			@(posedge clk);
			cross_req <= 2'h1;
			lag <= i ? 4'h6 : 4'h1;
			@(posedge clk);
			cross_req <= 2'h0;
			repeat (10) @(negedge clk);
			rd(5'h12);
			chk({15'h0000, v[2]}, 16'h0000);
		end
		poll_ext(1'b1);
		t0 = cyc;
		poll_ext(1'b0);
		chk(16'(cyc - t0 inside {[40:60]}), 16'h0001);
		wr(5'h01, 16'h0000);
		tally_and_finish();
	end
endmodule
